// File: logic/sle_basic_ec.sv
// Go-back-N terminal: sequence numbering, acknowledgement, retransmission.
// Assumes a framer on both link sides on the same clock, CRC pre-checked.
`timescale 1ns/1ps
`include "sle_map.svh"
module sle_basic_ec #(
  parameter int unsigned ACK_DELAY_US  = `SLE_ACK_DELAY_US,
  parameter int unsigned ACK_DELAY_CYC = ACK_DELAY_US * `SLE_CLK_MHZ
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                msg_valid,
  output logic                     msg_ready,
  input  wire sle_pkg::sle_data_t  msg_data,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output sle_pkg::sle_kind_e       out_kind,
  output sle_pkg::sle_seq_t        out_fsn,
  output logic                     out_fib,
  output sle_pkg::sle_seq_t        out_bsn,
  output logic                     out_bib,
  output sle_pkg::sle_data_t       out_data,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  input  wire logic                rx_crc_ok,
  input  wire sle_pkg::sle_kind_e  rx_kind,
  input  wire sle_pkg::sle_seq_t   rx_fsn,
  input  wire logic                rx_fib,
  input  wire sle_pkg::sle_seq_t   rx_bsn,
  input  wire logic                rx_bib,
  input  wire sle_pkg::sle_data_t  rx_data,
  output logic                     dlv_valid,
  input  wire logic                dlv_ready,
  output sle_pkg::sle_data_t       dlv_data,
  output logic                     status_valid,
  output sle_pkg::sle_data_t       status_data,
  output logic                     link_fault,
  output logic                     link_fail
);
  localparam logic [`SLE_CNT_W-1:0] ACK_LIM = ACK_DELAY_CYC[`SLE_CNT_W-1:0];

  sle_pkg::sle_state_s r;
  sle_pkg::sle_state_s n;
  sle_pkg::sle_data_t  retain_mem [0:`SLE_SEQ_DEPTH-1];
  sle_pkg::sle_seq_t   outstanding;
  sle_pkg::sle_seq_t   n_outstanding;
  sle_pkg::sle_seq_t   bsn_off;
  sle_pkg::sle_seq_t   fsn_rx_inc;
  sle_pkg::sle_seq_t   fsn_new;
  logic                slot_free;
  logic                take_new;
  logic                rx_take;
  logic                rx_seq;
  logic                bsn_bad;
  logic                fib_bad;
  logic                keep;
  logic                accept;
  logic                nak;
  logic                new_ack;
  logic                retx_start;
  logic                buf_in_ready;

  // Delivery to level 3 passes a two-entry buffer; a full buffer stalls rx
  sle_skid_buffer u_dlv_buf (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (accept),
    .in_ready  (buf_in_ready),
    .in_data   (rx_data),
    .out_valid (dlv_valid),
    .out_ready (dlv_ready),
    .out_data  (dlv_data)
  );

  assign rx_ready     = buf_in_ready;
  assign out_valid    = r.out_valid;
  assign out_kind     = r.out_kind;
  assign out_fsn      = r.out_fsn;
  assign out_fib      = r.out_fib;
  assign out_bsn      = r.out_bsn;
  assign out_bib      = r.out_bib;
  assign out_data     = r.out_data;
  assign status_valid = r.status_valid;
  assign status_data  = r.status_data;
  assign link_fault   = r.link_fault;
  assign link_fail    = r.link_fail;

  // Window arithmetic; 7-bit differences wrap modulo 128 by themselves
  assign outstanding = r.fsn_sent - r.fsn_acked;
  assign fsn_new     = r.fsn_sent + `SLE_SEQ_ONE;              // [RQ1]
  assign fsn_rx_inc  = r.fsn_rx + `SLE_SEQ_ONE;
  assign bsn_off     = rx_bsn - r.fsn_acked;
  assign slot_free   = !r.out_valid || out_ready;

  // New units wait for retransmission and for a free sequence number
  assign msg_ready = slot_free && !r.retx                       // [RQ19]
                     && (outstanding != `SLE_MAX_OUT);          // [RQ4]
  assign take_new  = msg_ready && msg_valid;

  // Receive qualification; a unit failing the check bits is just dropped
  assign rx_take = rx_valid && buf_in_ready;
  assign rx_seq  = rx_take && rx_crc_ok                         // [RQ23]
                   && (rx_kind != sle_pkg::sle_lssu);
  // Reasonable: equal to the previous ack or naming a retained unit
  assign bsn_bad = bsn_off > outstanding;                      // [RQ15]
  // Indicator toggled though no NAK of ours is waiting for it
  assign fib_bad = (rx_fib != r.rx_fib) && !r.nak_out;         // [RQ21]
  assign keep    = rx_seq && !bsn_bad && !fib_bad && !r.skip_next; // [RQ10]

  // Retained copies; the array is only written, never reset, so it maps
  // onto plain memory. The index is the forward number itself.
  always_ff @(posedge clock) begin
    if (take_new) begin
      retain_mem[fsn_new] <= msg_data;                          // [RQ3]
    end
  end

  // Next-state logic: transmit choice first, then receive processing,
  // so that a retransmission started by the peer overrides a pointer step
  always_comb begin
    n              = r;
    n.status_valid = 1'b0;
    n.link_fault   = 1'b0;
    n.link_fail    = 1'b0;
    accept         = 1'b0;
    nak            = 1'b0;
    new_ack        = 1'b0;
    retx_start     = 1'b0;

    // A unit is always on offer: retransmission, new message or fill-in
    if (slot_free) begin
      n.out_valid = 1'b1;
      n.out_bsn   = r.fsn_rx;                                   // [RQ11]
      n.out_bib   = r.bib;                                      // [RQ12]
      n.out_fib   = r.fib;                                      // [RQ20]
      if (r.retx) begin
        n.out_kind = sle_pkg::sle_msu;
        n.out_fsn  = r.retx_ptr;                                // [RQ18]
        n.out_data = retain_mem[r.retx_ptr];
        if (r.retx_ptr == r.fsn_sent) begin
          n.retx = 1'b0;                                        // [RQ19]
        end else begin
          n.retx_ptr = r.retx_ptr + `SLE_SEQ_ONE;
        end
      end else if (take_new) begin
        n.out_kind = sle_pkg::sle_msu;
        n.out_fsn  = fsn_new;                                   // [RQ1]
        n.out_data = msg_data;
        n.fsn_sent = fsn_new;
      end else begin
        n.out_kind = sle_pkg::sle_fisu;
        n.out_fsn  = r.fsn_sent;                                // [RQ2]
        n.out_data = '0;
      end
    end

    // Status units go straight up; they take no part in sequencing
    if (rx_take && rx_crc_ok && rx_kind == sle_pkg::sle_lssu) begin
      n.status_valid = 1'b1;                                    // [RQ5]
      n.status_data  = rx_data;
    end

    // Error history counts every checked unit, even a skipped one
    if (rx_seq) begin
      n.bsn_hist  = {r.bsn_hist[0], bsn_bad};
      n.fib_hist  = {r.fib_hist[0], fib_bad};
      n.skip_next = bsn_bad || fib_bad;                         // [RQ15]
      if (bsn_bad && r.bsn_hist != 2'b00) begin
        n.link_fault = 1'b1;                                    // [RQ16]
      end
      if (fib_bad && r.fib_hist != 2'b00) begin
        n.link_fault = 1'b1;                                    // [RQ22]
      end
    end

    if (keep) begin
      n.rx_fib = rx_fib;
      if (rx_fib == r.bib) begin
        n.nak_out = 1'b0;
      end
      // Backward side: a changed number releases everything up to it
      if (rx_bsn != r.fsn_acked) begin                          // [RQ14]
        n.fsn_acked = rx_bsn;                                   // [RQ13]
        new_ack     = 1'b1;
      end
      if (rx_bib != r.fib) begin
        retx_start = 1'b1;
        n.fib      = ~r.fib;                                    // [RQ20]
        n.retx_ptr = rx_bsn + `SLE_SEQ_ONE;                     // [RQ18]
        n.retx     = rx_bsn != n.fsn_sent;
      end
      // Forward side
      if (rx_kind == sle_pkg::sle_fisu) begin
        if (rx_fsn != r.fsn_rx && rx_fib == r.bib) begin
          nak = 1'b1;                                           // [RQ5]
        end
      end else if (rx_fsn == r.fsn_rx) begin
        accept = 1'b0;                                          // [RQ6]
      end else if (rx_fsn == fsn_rx_inc) begin
        accept = rx_fib == r.bib;                               // [RQ7] [RQ8]
      end else begin
        nak = rx_fib == r.bib;                                  // [RQ9]
      end
      if (accept) begin
        n.fsn_rx = rx_fsn;                                      // [RQ11]
      end
      if (nak) begin
        n.bib     = ~r.bib;                                     // [RQ12]
        n.nak_out = 1'b1;
      end
    end

    // Acknowledgement delay timer; saturates so failure is reported once
    n_outstanding = n.fsn_sent - n.fsn_acked;
    if (new_ack || n_outstanding == `SLE_SEQ_W'(0)) begin
      n.ack_cnt = '0;                                           // [RQ17]
    end else if (r.ack_cnt < ACK_LIM) begin
      n.ack_cnt = r.ack_cnt + `SLE_CNT_W'(1);                   // [RQ24]
      if (r.ack_cnt == ACK_LIM - `SLE_CNT_W'(1)) begin
        n.link_fail = 1'b1;                                     // [RQ17]
      end
    end
  end

  // State register; indicators start at one, numbers at the top value
  always_ff @(posedge clock) begin
    if (reset) begin
      r           <= '0;
      r.fsn_sent  <= `SLE_SEQ_INIT;
      r.fsn_acked <= `SLE_SEQ_INIT;
      r.fsn_rx    <= `SLE_SEQ_INIT;
      r.fib       <= 1'b1;
      r.bib       <= 1'b1;
      r.rx_fib    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Checks on the sequencing behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_fsn_incr;
    take_new |=> out_kind == sle_pkg::sle_msu
                 && out_fsn == $past(r.fsn_sent) + `SLE_SEQ_ONE;
  endproperty
  a_fsn_incr: assert property (p_fsn_incr) // [RQ1]
    else $error("new message unit number is not previous plus one");

  property p_fill_fsn;
    (slot_free && !r.retx && !take_new)
      |=> out_kind == sle_pkg::sle_fisu && out_fsn == r.fsn_sent;
  endproperty
  a_fill_fsn: assert property (p_fill_fsn) // [RQ2]
    else $error("fill-in unit does not carry last sent number");

  property p_window;
    take_new |-> outstanding != `SLE_MAX_OUT;
  endproperty
  a_window: assert property (p_window) // [RQ4]
    else $error("new unit taken with full window");

  property p_accept;
    accept |=> r.fsn_rx == $past(rx_fsn) && dlv_valid;
  endproperty
  a_accept: assert property (p_accept) // [RQ7]
    else $error("accepted unit not recorded or not delivered");

  property p_duplicate;
    (keep && rx_kind == sle_pkg::sle_msu && rx_fsn == r.fsn_rx)
      |=> $stable(r.fsn_rx) && $stable(r.bib);
  endproperty
  a_duplicate: assert property (p_duplicate) // [RQ6]
    else $error("duplicate message unit changed receive state");

  property p_nak;
    nak |=> r.bib != $past(r.bib) ##1 (slot_free || out_bib == r.bib);
  endproperty
  a_nak: assert property (p_nak) // [RQ12]
    else $error("negative acknowledgement did not invert indicator");

  property p_bsn_out;
    slot_free |=> out_bsn == $past(r.fsn_rx) && out_bib == $past(r.bib);
  endproperty
  a_bsn_out: assert property (p_bsn_out) // [RQ11]
    else $error("backward fields not from last accepted unit");

  property p_retx_fib;
    retx_start |=> r.fib != $past(r.fib)
                   && r.retx_ptr == $past(rx_bsn) + `SLE_SEQ_ONE;
  endproperty
  a_retx_fib: assert property (p_retx_fib) // [RQ20]
    else $error("retransmission start without indicator or pointer");

  property p_no_new;
    r.retx |-> !msg_ready;
  endproperty
  a_no_new: assert property (p_no_new) // [RQ19]
    else $error("new message accepted during retransmission");

  property p_skip;
    (rx_seq && (bsn_bad || fib_bad)) |=> r.skip_next && !accept;
  endproperty
  a_skip: assert property (p_skip) // [RQ15]
    else $error("unit after bad unit not marked for discard");

  property p_fail;
    (r.ack_cnt == ACK_LIM - `SLE_CNT_W'(1) && !new_ack
     && n_outstanding != `SLE_SEQ_W'(0)) |=> link_fail;
  endproperty
  a_fail: assert property (p_fail) // [RQ17]
    else $error("acknowledgement delay expiry not reported");

  property p_seq_discard;
    (keep && rx_kind == sle_pkg::sle_msu && rx_fsn == fsn_rx_inc
     && rx_fib != r.bib) |=> $stable(r.fsn_rx);
  endproperty
  a_seq_discard: assert property (p_seq_discard) // [RQ8]
    else $error("out-of-phase next message unit was accepted");

  property p_fill_nak;
    (keep && rx_kind == sle_pkg::sle_fisu && rx_fsn != r.fsn_rx
     && rx_fib == r.bib) |=> r.bib != $past(r.bib) && r.nak_out;
  endproperty
  a_fill_nak: assert property (p_fill_nak) // [RQ5]
    else $error("out-of-sequence fill-in did not cause a negative ack");

  property p_release;
    (keep && rx_bsn != r.fsn_acked) |=> r.fsn_acked == $past(rx_bsn);
  endproperty
  a_release: assert property (p_release) // [RQ13]
    else $error("backward number did not release retained units");

  property p_repeat_ack;
    (keep && rx_bsn == r.fsn_acked) |=> $stable(r.fsn_acked);
  endproperty
  a_repeat_ack: assert property (p_repeat_ack) // [RQ14]
    else $error("repeated acknowledgement changed transmit state");

  property p_bsn_fault;
    (rx_seq && bsn_bad && r.bsn_hist != 2'b00) |=> link_fault;
  endproperty
  a_bsn_fault: assert property (p_bsn_fault) // [RQ16]
    else $error("second bad backward number in three not reported");

  property p_fib_fault;
    (rx_seq && fib_bad && r.fib_hist != 2'b00) |=> link_fault;
  endproperty
  a_fib_fault: assert property (p_fib_fault) // [RQ22]
    else $error("second unrequested restart in three not reported");

  property p_crc_drop;
    (rx_take && !rx_crc_ok) |=> $stable(r.fsn_rx) && $stable(r.fsn_acked);
  endproperty
  a_crc_drop: assert property (p_crc_drop) // [RQ23]
    else $error("unit failing its check bits changed sequence state");

  property p_retx_send;
    (r.retx && slot_free) |=> out_kind == sle_pkg::sle_msu
                              && out_fsn == $past(r.retx_ptr);
  endproperty
  a_retx_send: assert property (p_retx_send) // [RQ18]
    else $error("retained unit not resent in order");
endmodule

// File: include/sle_map.svh
// Named constants of the basic error correction terminal controller.
// Assumes inclusion by the package and by every design file.
// Functional notes
// RQ1: New message unit gets previous forward number plus one, modulo 128.
// RQ2: Non-message units carry the forward number of the last sent message.
// RQ3: Retain each message unit and its number until positively acknowledged.
// RQ4: Assign a number only if acknowledged; at most 127 units outstanding.
// RQ5: Pass on fill-in and status units; fill-in out of sequence may NAK.
// RQ6: Message unit repeating the last accepted number is discarded.
// RQ7: Next-in-sequence message with matching indicator is delivered upward.
// RQ8: Next-in-sequence message with mismatching indicator is discarded.
// RQ9: Other message numbers are discarded; matching indicator also NAKs.
// RQ10: Skip acknowledgement handling for unreasonable backward number or bit.
// RQ11: Backward number sent is the last accepted forward number.
// RQ12: NAK inverts sent backward indicator and holds it until next NAK.
// RQ13: Received backward number releases that unit and all earlier ones.
// RQ14: A repeated identical positive acknowledgement causes no action.
// RQ15: Unreasonable backward number discards this unit and the next one.
// RQ16: Two bad backward numbers in three units report a link fault.
// RQ17: Acknowledgement delay timer expiry reports link failure upward.
// RQ18: Mismatching backward indicator resends retained units from bsn+1.
// RQ19: No new message unit until the retransmission has finished.
// RQ20: Invert forward indicator at each retransmission start and hold it.
// RQ21: Unrequested retransmission start discards this unit and the next.
// RQ22: Two unrequested starts in three units report a link fault.
// RQ23: Only units passing the check bits enter sequence processing.
// RQ24: Acknowledgement delay is an absolute time, set by parameter.
`ifndef SLE_MAP_SVH
`define SLE_MAP_SVH
`define SLE_SEQ_W        7
`define SLE_SEQ_DEPTH    128
`define SLE_DATA_W       32
`define SLE_CNT_W        32
`define SLE_SEQ_ONE      7'h01
`define SLE_SEQ_INIT     7'h7F
`define SLE_MAX_OUT      7'h7F
`define SLE_ACK_DELAY_US 1000
`define SLE_CLK_MHZ      100
`endif

// File: include/sle_pkg.sv
// Types of the basic error correction terminal controller.
// Assumes sle_map.svh sits in the include path.
`include "sle_map.svh"
package sle_pkg;
  typedef logic [`SLE_SEQ_W-1:0]  sle_seq_t;
  typedef logic [`SLE_DATA_W-1:0] sle_data_t;

  typedef enum logic [1:0] {
    sle_fisu = 2'b00,
    sle_lssu = 2'b01,
    sle_msu  = 2'b10
  } sle_kind_e;

  typedef struct packed {
    logic      main_v;
    sle_data_t main_d;
    logic      skid_v;
    sle_data_t skid_d;
  } sle_buf_s;

  typedef struct packed {
    sle_seq_t              fsn_sent;
    sle_seq_t              fsn_acked;
    sle_seq_t              fsn_rx;
    logic                  fib;
    logic                  bib;
    logic                  rx_fib;
    logic                  nak_out;
    logic                  retx;
    sle_seq_t              retx_ptr;
    logic                  skip_next;
    logic [1:0]            bsn_hist;
    logic [1:0]            fib_hist;
    logic [`SLE_CNT_W-1:0] ack_cnt;
    logic                  out_valid;
    sle_kind_e             out_kind;
    sle_seq_t              out_fsn;
    sle_seq_t              out_bsn;
    logic                  out_fib;
    logic                  out_bib;
    sle_data_t             out_data;
    logic                  status_valid;
    sle_data_t             status_data;
    logic                  link_fault;
    logic                  link_fail;
  } sle_state_s;
endpackage

// File: logic/sle_skid_buffer.sv
// Two-entry buffer between accepted message units and level 3.
// Assumes a single clock and a consumer that may stall at will.
`timescale 1ns/1ps
`include "sle_map.svh"
module sle_skid_buffer (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire sle_pkg::sle_data_t  in_data,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output sle_pkg::sle_data_t       out_data
);
  sle_pkg::sle_buf_s r;
  sle_pkg::sle_buf_s n;

  // Ready depends only on the skid slot so it never loops back to in_valid
  assign in_ready  = !r.skid_v;
  assign out_valid = r.main_v;
  assign out_data  = r.main_d;

  // Pop first, then place the new word in the first free slot
  always_comb begin
    n = r;
    if (out_ready && r.main_v) begin
      n.main_v = r.skid_v;
      n.main_d = r.skid_d;
      n.skid_v = 1'b0;
    end
    if (in_valid && !r.skid_v) begin
      if (!n.main_v) begin
        n.main_v = 1'b1;
        n.main_d = in_data;
      end else begin
        n.skid_v = 1'b1;
        n.skid_d = in_data;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// File: testbench/sle_peer_model.sv
// Far-end terminal receiver: takes units from the controller and logs them.
// Assumes the controller's clock and its synchronous active-high reset.
`timescale 1ns/1ps
module sle_peer_model (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               stall,
  input  wire logic               out_valid,
  input  wire sle_pkg::sle_kind_e out_kind,
  input  wire sle_pkg::sle_seq_t  out_fsn,
  input  wire logic               out_fib,
  input  wire sle_pkg::sle_data_t out_data,
  output logic                    out_ready
);
  logic [7:0]  log_id[$];
  logic [31:0] log_data[$];
  logic [6:0]  fill_fsn;

  // A slow far end holds the unit on the line rather than dropping it
  assign out_ready = !stall;

  // Message units are logged with indicator; fill-in keeps its number
  always @(posedge clock) begin
    if (reset) begin
      fill_fsn <= 7'h00;
    end else if (out_valid && out_ready) begin
      if (out_kind == sle_pkg::sle_msu) begin
        log_id.push_back({out_fib, out_fsn});
        log_data.push_back(out_data);
      end else begin
        fill_fsn <= out_fsn;
      end
    end
  end
endmodule

// File: testbench/signalling_link_basic_error_correction_tb_top.sv
// Self-checking bench of the basic error correction controller.
// Assumes the package, design files and peer model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module signalling_link_basic_error_correction_tb_top;
  localparam logic [1:0] F = 2'h0;
  localparam logic [1:0] L = 2'h1;
  localparam logic [1:0] M = 2'h2;
  logic               clock, reset, stall, msg_valid, msg_ready;
  logic               out_valid, out_ready, out_fib, out_bib;
  sle_pkg::sle_kind_e out_kind, rx_kind;
  sle_pkg::sle_seq_t  out_fsn, out_bsn, rx_fsn, rx_bsn;
  sle_pkg::sle_data_t msg_data, out_data, rx_data, dlv_data, status_data;
  logic               rx_valid, rx_ready, rx_crc_ok, rx_fib, rx_bib;
  logic               dlv_valid, dlv_ready, status_valid;
  logic               link_fault, link_fail;
  int                 error_cnt, total_checks, cyc, n_fail, n_fault, n_stat;
  logic [31:0]        dlv_q[$];
  logic [7:0]         exp_id[8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84,
                                    8'h03, 8'h04, 8'h05};

  // Short timer so an acknowledgement timeout shows within the run
  sle_basic_ec #(.ACK_DELAY_CYC(50)) dut (
    .clock, .reset, .msg_valid, .msg_ready, .msg_data, .out_valid,
    .out_ready, .out_kind, .out_fsn, .out_fib, .out_bsn, .out_bib,
    .out_data, .rx_valid, .rx_ready, .rx_crc_ok, .rx_kind, .rx_fsn,
    .rx_fib, .rx_bsn, .rx_bib, .rx_data, .dlv_valid, .dlv_ready,
    .dlv_data, .status_valid, .status_data, .link_fault, .link_fail
  );

  sle_peer_model peer (
    .clock, .reset, .stall, .out_valid, .out_kind, .out_fsn, .out_fib,
    .out_data, .out_ready
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Deliveries and pulses are counted here so no pulse is missed
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (dlv_valid && dlv_ready) dlv_q.push_back(dlv_data);
    if (link_fail) n_fail <= n_fail + 1;
    if (link_fault) n_fault <= n_fault + 1;
    if (status_valid) n_stat <= n_stat + 1;
  end

  // A hang ends the run as a failure
  always @(posedge clock) begin
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge clock);
  endtask

  // One received unit, held until the controller takes it
  task automatic rx(input logic [1:0] k, input logic [6:0] f,
                    input logic fb, input logic [6:0] b, input logic bb,
                    input logic [31:0] d, input logic ok = 1'b1);
    int n = 0;
    @(negedge clock);
    rx_kind = sle_pkg::sle_kind_e'(k);
    {rx_valid, rx_fsn, rx_fib, rx_bsn, rx_bib} = {1'b1, f, fb, b, bb};
    {rx_data, rx_crc_ok} = {d, ok};
    while (!rx_ready && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    rx_valid = 1'b0;
  endtask

  // One message word from level 3, held until accepted
  task automatic tx(input logic [31:0] d);
    int n = 0;
    @(negedge clock);
    {msg_valid, msg_data} = {1'b1, d};
    // Ready is read once other falling-edge drivers have settled
    #1;
    while (!msg_ready && n < 200) begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    msg_valid = 1'b0;
  endtask

  initial begin
    {reset, stall, msg_valid, msg_data, rx_valid, rx_crc_ok} = '1;
    {stall, msg_valid, msg_data, rx_valid} = '0;
    {rx_fsn, rx_fib, rx_bsn, rx_bib, rx_data, dlv_ready} = '0;
    rx_kind = sle_pkg::sle_fisu;
    dlv_ready = 1'b1;
    wt(16);
    reset = 1'b0;
    wt(3);
    `CHK({out_kind, out_fsn, out_fib, out_bsn, out_bib},
         {F, 7'h7F, 1'b1, 7'h7F, 1'b1});
    rx(L, 7'h7F, 1'b1, 7'h7F, 1'b1, 32'hA5);
    wt(2);
    `CHK(n_stat, 1);
    `CHK(status_data, 32'hA5);
    // Sending, with the far end stalling while the first word is on the line
    tx(32'h10);
    stall = 1'b1;
    fork
      tx(32'h11);
      begin
        wt(5);
        stall = 1'b0;
      end
    join
    tx(32'h12);
    wt(4);
    `CHK(peer.fill_fsn, 7'h02);
    wt(70);
    `CHK(n_fail, 1);
    repeat (3) rx(F, 7'h7F, 1'b1, 7'h02, 1'b1, 32'h0);
    wt(70);
    `CHK(n_fail, 1);
    // Receive sequencing; E-words must never reach level 3
    rx(M, 7'h00, 1'b1, 7'h02, 1'b1, 32'hD0);
    wt(3);
    `CHK(out_bsn, 7'h00);
    rx(M, 7'h00, 1'b1, 7'h02, 1'b1, 32'hE0);
    rx(M, 7'h01, 1'b1, 7'h02, 1'b1, 32'hE1, 1'b0);
    rx(M, 7'h01, 1'b0, 7'h02, 1'b1, 32'hE2);
    rx(M, 7'h01, 1'b1, 7'h02, 1'b1, 32'hE3);
    rx(M, 7'h01, 1'b1, 7'h02, 1'b1, 32'hD1);
    rx(M, 7'h05, 1'b1, 7'h02, 1'b1, 32'hE5);
    wt(3);
    `CHK({out_bsn, out_bib}, {7'h01, 1'b0});
    rx(M, 7'h02, 1'b1, 7'h02, 1'b1, 32'hE7);
    rx(M, 7'h02, 1'b0, 7'h02, 1'b1, 32'hD2);
    wt(3);
    `CHK({out_bsn, out_bib}, {7'h02, 1'b0});
    // Go-back-N: peer requests 3 and 4 again while 5 waits
    tx(32'h13);
    tx(32'h14);
    rx(F, 7'h02, 1'b0, 7'h02, 1'b0, 32'h0);
    tx(32'h15);
    // Unreasonable backward numbers, two in three units
    rx(F, 7'h02, 1'b0, 7'h3C, 1'b0, 32'h0);
    rx(M, 7'h03, 1'b0, 7'h02, 1'b0, 32'hE6);
    rx(F, 7'h02, 1'b0, 7'h3D, 1'b0, 32'h0);
    rx(F, 7'h02, 1'b0, 7'h02, 1'b0, 32'h0);
    rx(M, 7'h03, 1'b0, 7'h02, 1'b0, 32'hD3);
    wt(2);
    `CHK(n_fault, 1);
    // Level 3 stalls until the two-entry buffer refuses
    dlv_ready = 1'b0;
    rx(M, 7'h04, 1'b0, 7'h02, 1'b0, 32'hD4);
    rx(M, 7'h05, 1'b0, 7'h02, 1'b0, 32'hD5);
    wt(3);
    `CHK(rx_ready, 1'b0);
    dlv_ready = 1'b1;
    wt(4);
    rx(F, 7'h05, 1'b1, 7'h02, 1'b0, 32'h0);
    rx(F, 7'h05, 1'b1, 7'h02, 1'b0, 32'h0);
    wt(2);
    `CHK(n_fault, 2);
    rx(F, 7'h05, 1'b0, 7'h02, 1'b0, 32'h0);
    rx(F, 7'h07, 1'b0, 7'h02, 1'b0, 32'h0);
    wt(3);
    `CHK({out_bsn, out_bib}, {7'h05, 1'b1});
    `CHK(peer.log_id.size(), 8);
    foreach (exp_id[i]) begin
      `CHK(peer.log_id[i], exp_id[i]);
      `CHK(peer.log_data[i], 32'h10 + exp_id[i][6:0]);
    end
    `CHK(dlv_q.size(), 6);
    for (int i = 0; i < 6; i++) begin
      `CHK(dlv_q[i], 32'hD0 + i);
    end
    summarize();
  end
endmodule
